// >>> verilog/gpio_pkg.sv
`default_nettype none
package gpio_pkg;
	// ****************************************
	// Port geometry
	// ****************************************
	localparam int NPINS = 12;
	localparam int NWAKE = 11;
	localparam int AW = 5;
	localparam int DW = 12;

	// ****************************************
	// I/O bus register indexes
	// ****************************************
	localparam logic [4:0] ADR_DATA = 5'h00;
	localparam logic [4:0] ADR_MASK = 5'h01;
	localparam logic [4:0] ADR_MDATA = 5'h02;
	localparam logic [4:0] ADR_SET = 5'h03;
	localparam logic [4:0] ADR_CLR = 5'h04;
	localparam logic [4:0] ADR_TOG = 5'h05;
	localparam logic [4:0] ADR_DIR = 5'h06;
	localparam logic [4:0] ADR_DIR_SET = 5'h07;
	localparam logic [4:0] ADR_DIR_CLR = 5'h08;
	localparam logic [4:0] ADR_DIR_TOG = 5'h09;
	localparam logic [4:0] ADR_IRQ_EN = 5'h0A;
	localparam logic [4:0] ADR_IRQ_STAT = 5'h0B;
	localparam logic [4:0] ADR_CFG_BASE = 5'h10;
	localparam logic [4:0] ADR_CFG_LAST = 5'h1B;

	// ****************************************
	// Pad configuration word layout
	// ****************************************
	localparam int CFG_PIN_FUNCTION_SELECT_LSB = 0;
	localparam int CFG_PIN_FUNCTION_SELECT_MSB = 2;
	localparam int CFG_PULL_LSB = 3;
	localparam int CFG_PULL_MSB = 4;
	localparam int CFG_HYST = 5;
	localparam int CFG_INMODE = 6;
	localparam int CFG_FILT = 7;
	localparam int CFG_BUS_PLAIN = 8;
	localparam int CFG_SINK = 9;
	localparam int CFG_ILO = 10;
	localparam int CFG_IHI = 11;

	localparam logic [2:0] PIN_FUNCTION_SELECT_GPIO = 3'h0;
	localparam logic [1:0] PULL_NONE = 2'h0;
	localparam logic [1:0] PULL_DOWN = 2'h1;
	localparam logic [1:0] PULL_UP = 2'h2;
	localparam logic [1:0] PULL_REPEAT = 2'h3;

	// ****************************************
	// Reset values and pin classes
	// ****************************************
	localparam logic [11:0] CFG_RST_GPIO = 12'h000;
	localparam logic [11:0] CFG_RST_ALT = 12'h001;
	localparam logic [11:0] ALT_RST_PINS = 12'hC30;
	localparam logic [11:0] HIGH_DRIVE_PINS = 12'hC88;
	localparam logic [11:0] BUS_PINS = 12'h030;
	localparam logic [11:0] ZERO12 = 12'h000;
	localparam logic [4:0] PORT_IRQ_LINE = 5'h1F;
endpackage
`default_nettype wire

// >>> verilog/gpio_port_with_pad_config.sv
// Summary of operation
// RL1 - Function field zero selects general-purpose port
// RL2 - In port mode direction bit sets drive
// RL3 - Peripheral function owns direction, register ignored
// RL4 - Pull field: up, down, none, repeater
// RL5 - Pull field resets to no resistor
// RL6 - Repeater pulls toward the pin's level
// RL7 - No repeater retention in deep power-down
// RL8 - Reset: inputs, no pulls; bus, debug excepted
// RL9 - Bus pins choose filtered or plain open-drain
// RL10 - Config controls input mode, hysteresis, filter
// RL11 - High-drive pins offer digital or current sink
// RL12 - Set and clear writes touch chosen bits
// RL13 - Whole-port write with masked variant
// RL14 - Direction bits set, cleared, toggled individually
// RL15 - Single-cycle dedicated I/O bus access
// RL16 - Each port bit fixed to one pin
// RL17 - Pins 0 to 10 drive wake lines
// RL18 - Combined status goes out as line 31
// RL19 - Data read returns synced pins or drive
`default_nettype none
module gpio_port_with_pad_config (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic io_sel_i,
	input wire logic io_wr_i,
	input wire logic [4:0] io_addr_i,
	input wire logic [11:0] io_wdata_i,
	output logic [11:0] io_rdata_o,
	input wire logic [11:0] pin_i,
	output logic [11:0] pin_out_o,
	output logic [11:0] pin_oe_n_o,
	output logic [11:0] pull_up_o,
	output logic [11:0] pull_dn_o,
	output logic [11:0] hyst_o,
	output logic [11:0] inmode_o,
	output logic [11:0] filt_o,
	output logic [11:0] bus_glitch_o,
	output logic [11:0] sink_en_o,
	output logic [11:0] sink_sel_o,
	input wire logic [11:0] periph_out_i,
	input wire logic [11:0] periph_oe_i,
	output logic [11:0] periph_in_o,
	input wire logic deep_pd_i,
	output logic [10:0] wake_o,
	output logic port_irq_o
);

	// ****************************************
	// Pin input synchronisers
	// ****************************************
	logic [11:0] sync1_reg;
	logic [11:0] sync2_reg;
	logic [11:0] prev_reg;

	// Two stages guard against metastable pad levels
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sync1_reg <= gpio_pkg::ZERO12;
			sync2_reg <= gpio_pkg::ZERO12;
			prev_reg <= gpio_pkg::ZERO12;
		end
		else
		begin
			sync1_reg <= pin_i;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	// ****************************************
	// Bus decode
	// ****************************************
	logic wr;
	logic rd;
	logic wr_data;
	logic wr_mask;
	logic wr_mdata;
	logic wr_set;
	logic wr_clr;
	logic wr_tog;
	logic wr_dir;
	logic wr_dset;
	logic wr_dclr;
	logic wr_dtog;
	logic wr_ien;
	logic wr_ist;
	logic cfg_hit;
	logic [3:0] cfg_idx;

	// One strobe per index; every access finishes in the cycle it is seen
	assign wr = io_sel_i && io_wr_i; // RL15
	assign rd = io_sel_i && !io_wr_i;
	assign wr_data = wr && (io_addr_i == gpio_pkg::ADR_DATA);
	assign wr_mask = wr && (io_addr_i == gpio_pkg::ADR_MASK);
	assign wr_mdata = wr && (io_addr_i == gpio_pkg::ADR_MDATA);
	assign wr_set = wr && (io_addr_i == gpio_pkg::ADR_SET);
	assign wr_clr = wr && (io_addr_i == gpio_pkg::ADR_CLR);
	assign wr_tog = wr && (io_addr_i == gpio_pkg::ADR_TOG);
	assign wr_dir = wr && (io_addr_i == gpio_pkg::ADR_DIR);
	assign wr_dset = wr && (io_addr_i == gpio_pkg::ADR_DIR_SET);
	assign wr_dclr = wr && (io_addr_i == gpio_pkg::ADR_DIR_CLR);
	assign wr_dtog = wr && (io_addr_i == gpio_pkg::ADR_DIR_TOG);
	assign wr_ien = wr && (io_addr_i == gpio_pkg::ADR_IRQ_EN);
	assign wr_ist = wr && (io_addr_i == gpio_pkg::ADR_IRQ_STAT);
	// Pad words sit in one window, one index per pin
	assign cfg_hit = (io_addr_i >= gpio_pkg::ADR_CFG_BASE) &&
		(io_addr_i <= gpio_pkg::ADR_CFG_LAST);
	assign cfg_idx = 4'(io_addr_i - gpio_pkg::ADR_CFG_BASE);

	// ****************************************
	// Output data, mask and direction
	// ****************************************
	logic [11:0] out_reg;
	logic [11:0] out_next;
	logic [11:0] mask_reg;
	logic [11:0] dir_reg;
	logic [11:0] dir_next;

	// Mask bit high protects that output from a masked write
	wire [11:0] masked_val = (out_reg & mask_reg) | (io_wdata_i & ~mask_reg); // RL13

	// Set, clear and toggle leave unselected bits alone
	assign out_next = wr_data ? io_wdata_i : // RL13
		wr_mdata ? masked_val :
		wr_set ? (out_reg | io_wdata_i) : // RL12
		wr_clr ? (out_reg & ~io_wdata_i) : // RL12
		wr_tog ? (out_reg ^ io_wdata_i) :
		out_reg;

	assign dir_next = wr_dir ? io_wdata_i :
		wr_dset ? (dir_reg | io_wdata_i) : // RL14
		wr_dclr ? (dir_reg & ~io_wdata_i) : // RL14
		wr_dtog ? (dir_reg ^ io_wdata_i) : // RL14
		dir_reg;

	// All port bits come up as inputs
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			out_reg <= gpio_pkg::ZERO12;
			mask_reg <= gpio_pkg::ZERO12;
			dir_reg <= gpio_pkg::ZERO12; // RL8
		end
		else
		begin
			out_reg <= out_next;
			mask_reg <= wr_mask ? io_wdata_i : mask_reg;
			dir_reg <= dir_next;
		end
	end

	// ****************************************
	// Per-pin pad configuration
	// ****************************************
	logic [11:0] cfg_reg [gpio_pkg::NPINS];
	logic [11:0] drive_en;
	logic [11:0] drive_val;
	logic [11:0] up_next;
	logic [11:0] dn_next;
	logic [11:0] hyst_next;
	logic [11:0] inm_next;
	logic [11:0] filt_next;
	logic [11:0] glitch_next;
	logic [11:0] sink_next;
	logic [11:0] ssel_next;
	logic [11:0] is_gpio;

	genvar g;
	generate
		for (g = 0; g < gpio_pkg::NPINS; g++)
		begin : pin_g
			// Bus and debug pins come up on their alternate function
			localparam logic [11:0] RST = gpio_pkg::ALT_RST_PINS[g] ?
				gpio_pkg::CFG_RST_ALT : gpio_pkg::CFG_RST_GPIO;
			wire [11:0] c = cfg_reg[g];
			wire [2:0] pin_function_select = c[gpio_pkg::CFG_PIN_FUNCTION_SELECT_MSB:gpio_pkg::CFG_PIN_FUNCTION_SELECT_LSB];
			wire [1:0] pull = c[gpio_pkg::CFG_PULL_MSB:gpio_pkg::CFG_PULL_LSB];
			// Repeater needs live pad state; lost in deep power-down
			wire rep = (pull == gpio_pkg::PULL_REPEAT) && !deep_pd_i; // RL7

			always_ff @(posedge clk_i or negedge nrst_i)
			begin
				if (!nrst_i)
					cfg_reg[g] <= RST; // RL5 RL8
				else if (wr && cfg_hit && (cfg_idx == 4'(g)))
					cfg_reg[g] <= io_wdata_i;
			end

			// Bit g of the port maps only onto pin g
			assign is_gpio[g] = (pin_function_select == gpio_pkg::PIN_FUNCTION_SELECT_GPIO); // RL1 RL16
			assign drive_en[g] = is_gpio[g] ? dir_reg[g] : periph_oe_i[g]; // RL2 RL3
			assign drive_val[g] = is_gpio[g] ? out_reg[g] : periph_out_i[g];
			assign up_next[g] = (pull == gpio_pkg::PULL_UP) || (rep && sync2_reg[g]); // RL4 RL6
			assign dn_next[g] = (pull == gpio_pkg::PULL_DOWN) || (rep && !sync2_reg[g]); // RL4 RL6
			assign hyst_next[g] = c[gpio_pkg::CFG_HYST]; // RL10
			assign inm_next[g] = c[gpio_pkg::CFG_INMODE]; // RL10
			assign filt_next[g] = c[gpio_pkg::CFG_FILT]; // RL10
			// Filtered open-drain only when the bus function is live
			assign glitch_next[g] = gpio_pkg::BUS_PINS[g] && !is_gpio[g] &&
				!c[gpio_pkg::CFG_BUS_PLAIN]; // RL9
			assign sink_next[g] = gpio_pkg::HIGH_DRIVE_PINS[g] && c[gpio_pkg::CFG_SINK]; // RL11
			assign ssel_next[g] = drive_val[g] ? c[gpio_pkg::CFG_IHI] : c[gpio_pkg::CFG_ILO]; // RL11
		end
	endgenerate

	// Bus pins in bus function are true open-drain: never drive high
	wire [11:0] od = gpio_pkg::BUS_PINS & ~is_gpio; // RL9
	wire [11:0] oe_n_next = ~drive_en | (od & drive_val);
	wire [11:0] pad_val = drive_val & ~od;

	// ****************************************
	// Pin interrupt status
	// ****************************************
	logic [11:0] ien_reg;
	logic [11:0] ist_reg;
	wire [11:0] rise = sync2_reg & ~prev_reg;
	// A new edge beats a clear in the same cycle
	wire [11:0] ist_next = rise | (ist_reg & ~(wr_ist ? io_wdata_i : gpio_pkg::ZERO12));

	// ****************************************
	// Read mux
	// ****************************************
	logic [11:0] rdata;
	// Outputs read back the driven value, inputs the pin
	wire [11:0] port_rd = (drive_en & drive_val) | (~drive_en & sync2_reg); // RL19
	always_comb
	begin
		rdata = gpio_pkg::ZERO12;
		if (cfg_hit)
			rdata = cfg_reg[cfg_idx];
		else
		begin
			unique case (io_addr_i)
				gpio_pkg::ADR_DATA: rdata = port_rd;
				gpio_pkg::ADR_MDATA: rdata = port_rd & ~mask_reg;
				gpio_pkg::ADR_MASK: rdata = mask_reg;
				gpio_pkg::ADR_DIR: rdata = dir_reg;
				gpio_pkg::ADR_IRQ_EN: rdata = ien_reg;
				gpio_pkg::ADR_IRQ_STAT: rdata = ist_reg;
				default: rdata = gpio_pkg::ZERO12;
			endcase
		end
	end

	// ****************************************
	// Output registers
	// ****************************************
	// Read data holds until the next read; no bus wait states
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			io_rdata_o <= gpio_pkg::ZERO12;
		end
		else
		begin
			io_rdata_o <= rd ? rdata : io_rdata_o; // RL15
		end
	end

	// Pad drive and pulls; pads see one cycle lag after a write
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			pin_out_o <= gpio_pkg::ZERO12;
			pin_oe_n_o <= ~gpio_pkg::ZERO12;
			pull_up_o <= gpio_pkg::ZERO12;
			pull_dn_o <= gpio_pkg::ZERO12;
		end
		else
		begin
			pin_out_o <= pad_val;
			pin_oe_n_o <= oe_n_next; // RL2 RL3
			pull_up_o <= up_next;
			pull_dn_o <= dn_next;
		end
	end

	// Static pad modes, registered so the pads never see decode glitches
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			hyst_o <= gpio_pkg::ZERO12;
			inmode_o <= gpio_pkg::ZERO12;
			filt_o <= gpio_pkg::ZERO12;
			bus_glitch_o <= gpio_pkg::ZERO12;
			sink_en_o <= gpio_pkg::ZERO12;
			sink_sel_o <= gpio_pkg::ZERO12;
		end
		else
		begin
			hyst_o <= hyst_next;
			inmode_o <= inm_next;
			filt_o <= filt_next;
			bus_glitch_o <= glitch_next;
			sink_en_o <= sink_next;
			sink_sel_o <= ssel_next & sink_next;
		end
	end

	// Synced levels to peripherals and the wake-up logic
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			periph_in_o <= gpio_pkg::ZERO12;
			wake_o <= gpio_pkg::ZERO12[gpio_pkg::NWAKE-1:0];
		end
		else
		begin
			periph_in_o <= sync2_reg;
			wake_o <= sync2_reg[gpio_pkg::NWAKE-1:0]; // RL17
		end
	end

	// Interrupt enable, sticky status and the combined line
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ien_reg <= gpio_pkg::ZERO12;
			ist_reg <= gpio_pkg::ZERO12;
			port_irq_o <= 1'b0;
		end
		else
		begin
			ien_reg <= wr_ien ? io_wdata_i : ien_reg;
			ist_reg <= ist_next;
			port_irq_o <= |(ist_next & ien_reg); // RL18
		end
	end

endmodule // gpio_port_with_pad_config
`default_nettype wire

// >>> test/gpio_port_monitor.sv
`default_nettype none
module gpio_port_monitor (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic io_sel_i,
	input wire logic io_wr_i,
	input wire logic [4:0] io_addr_i,
	input wire logic [11:0] io_wdata_i,
	input wire logic [11:0] io_rdata_o,
	input wire logic [11:0] pin_i,
	input wire logic [11:0] pull_up_o,
	input wire logic [11:0] pull_dn_o,
	input wire logic [11:0] bus_glitch_o,
	input wire logic [11:0] sink_en_o,
	input wire logic [11:0] periph_in_o,
	input wire logic [10:0] wake_o,
	input wire logic port_irq_o
);
	// ****
	// Port checks
	// ****
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	// Pins quiet long enough to pass both sync stages and the output flop
	sequence s_quiet;
		$stable(pin_i) [*5];
	endsequence
	sequence s_irq_off;
		io_sel_i && io_wr_i && io_addr_i == gpio_pkg::ADR_IRQ_EN && io_wdata_i == 12'h000
		##1 !(io_sel_i && io_wr_i && io_addr_i == gpio_pkg::ADR_IRQ_EN);
	endsequence
	property p_pull_excl; (pull_up_o & pull_dn_o) == 12'h000; endproperty
	a_pull_excl: assert property (p_pull_excl) else $error("pulls fight");
	property p_rst_pull; $rose(nrst_i) |-> (pull_up_o | pull_dn_o) == 12'h000; endproperty
	a_rst_pull: assert property (p_rst_pull) else $error("pull after reset");
	property p_bus; (bus_glitch_o & ~gpio_pkg::BUS_PINS) == 12'h000; endproperty
	a_bus: assert property (p_bus) else $error("bus mode on wrong pin");
	property p_sink; (sink_en_o & ~gpio_pkg::HIGH_DRIVE_PINS) == 12'h000; endproperty
	a_sink: assert property (p_sink) else $error("sink on wrong pin");
	property p_wake; s_quiet |-> wake_o == pin_i[10:0]; endproperty
	a_wake: assert property (p_wake) else $error("wake line off");
	property p_sync; s_quiet |-> periph_in_o == pin_i; endproperty
	a_sync: assert property (p_sync) else $error("synced level off");
	property p_unmapped; io_sel_i && !io_wr_i && io_addr_i == 5'h0C |=> io_rdata_o == 12'h000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	property p_irq_off; s_irq_off |=> !port_irq_o; endproperty
	a_irq_off: assert property (p_irq_off) else $error("masked irq seen");
endmodule // gpio_port_monitor
bind gpio_port_with_pad_config gpio_port_monitor gpio_port_monitor_i (.clk_i, .nrst_i,
	.io_sel_i, .io_wr_i, .io_addr_i, .io_wdata_i, .io_rdata_o, .pin_i, .pull_up_o,
	.pull_dn_o, .bus_glitch_o, .sink_en_o, .periph_in_o, .wake_o, .port_irq_o);
`default_nettype wire

// >>> test/pad_board_model.sv
`default_nettype none
module pad_board_model (
	input wire logic clk_i,
	input wire logic [11:0] pin_out_i,
	input wire logic [11:0] pin_oe_n_i,
	input wire logic [11:0] pull_up_i,
	input wire logic [11:0] pull_dn_i,
	input wire logic [11:0] ext_val_i,
	input wire logic [11:0] ext_en_i,
	output logic [11:0] pin_o
);
	// ****
	// Board side of the pads
	// ****
	logic [11:0] float_reg = 12'h000;
	// Loose pads wander, so a missing drive cannot pass by luck
	always_ff @(posedge clk_i)
		float_reg <= ~float_reg;
	// Pad drive beats board drive, board beats pulls
	always_comb
		for (int n = 0; n < 12; n++)
			pin_o[n] = !pin_oe_n_i[n] ? pin_out_i[n] : ext_en_i[n] ? ext_val_i[n] :
				pull_up_i[n] ? 1'b1 : pull_dn_i[n] ? 1'b0 : float_reg[n];
endmodule // pad_board_model
`default_nettype wire

// >>> test/gpio_port_with_pad_config_tb.sv
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
	$display("BAD t=%0t got %h exp %h", $time, a, e); end end
module gpio_port_with_pad_config_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, nrst_i = 0, io_sel_i = 0, io_wr_i = 0, deep_pd_i = 0;
	logic [4:0] io_addr_i = 5'h00;
	logic [11:0] io_wdata_i = 12'h000, periph_out_i = 12'h000, periph_oe_i = 12'h000;
	logic [11:0] ext_val = 12'h000, ext_en = 12'h000;
	wire logic [11:0] pin_i, pin_out_o, pin_oe_n_o, pull_up_o, pull_dn_o, io_rdata_o, hyst_o;
	wire logic [11:0] inmode_o, filt_o, bus_glitch_o, sink_en_o, sink_sel_o, periph_in_o;
	wire logic [10:0] wake_o;
	wire logic port_irq_o;
	int miscompares = 0, samples_checked = 0, cycles = 0;
	// ****
	// Block, board and clock
	// ****
	gpio_port_with_pad_config gpio_port_with_pad_config_i (.clk_i, .nrst_i, .io_sel_i,
		.io_wr_i, .io_addr_i, .io_wdata_i, .io_rdata_o, .pin_i, .pin_out_o, .pin_oe_n_o,
		.pull_up_o, .pull_dn_o, .hyst_o, .inmode_o, .filt_o, .bus_glitch_o, .sink_en_o,
		.sink_sel_o, .periph_out_i, .periph_oe_i, .periph_in_o, .deep_pd_i, .wake_o,
		.port_irq_o);
	pad_board_model pad_board_model_i (.clk_i, .pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o),
		.pull_up_i(pull_up_o), .pull_dn_i(pull_dn_o), .ext_val_i(ext_val), .ext_en_i(ext_en),
		.pin_o(pin_i));
	initial
		forever #2.5 clk_i = ~clk_i;
	// Hang guard, far above the 150 or so cycles the run needs
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			miscompares++;
			test_done();
		end
	end
	// Requests are raised after an edge and held until the next one samples them
	task automatic wr(input logic [4:0] a, input logic [11:0] d);
		@(posedge clk_i);
		{io_sel_i, io_wr_i, io_addr_i, io_wdata_i} <= {2'b11, a, d};
	endtask
	// Generous settle covers the two sync flops and output registers
	task automatic idle();
		@(posedge clk_i);
		io_sel_i <= 1'b0;
		repeat (5) @(posedge clk_i);
	endtask
	task automatic rd(input logic [4:0] a, input logic [11:0] m, input logic [11:0] e);
		@(posedge clk_i);
		{io_sel_i, io_wr_i, io_addr_i} <= {2'b10, a};
		idle();
		`CHK(io_rdata_o & m, e)
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (4) @(posedge clk_i);
		nrst_i <= 1'b1;
		idle();
		`CHK({pull_up_o, pull_dn_o, pin_oe_n_o}, 36'h000000FFF)
		`CHK(bus_glitch_o, gpio_pkg::BUS_PINS)
		rd(5'h14, 12'hFFF, gpio_pkg::CFG_RST_ALT);
		rd(5'h0C, 12'hFFF, 12'h000);
		wr(gpio_pkg::ADR_DIR_SET, 12'h03F);
		wr(gpio_pkg::ADR_DATA, 12'h000);
		wr(gpio_pkg::ADR_SET, 12'h005);
		wr(gpio_pkg::ADR_CLR, 12'h001);
		idle();
		`CHK(pin_oe_n_o, 12'hFF0)
		rd(gpio_pkg::ADR_DATA, 12'h00F, 12'h004);
		wr(gpio_pkg::ADR_MASK, 12'h00E);
		wr(gpio_pkg::ADR_MDATA, 12'h00F);
		wr(gpio_pkg::ADR_MASK, 12'h000);
		rd(gpio_pkg::ADR_DATA, 12'h00F, 12'h005);
		wr(gpio_pkg::ADR_TOG, 12'h003);
		wr(gpio_pkg::ADR_DIR_CLR, 12'h001);
		wr(gpio_pkg::ADR_DIR_TOG, 12'h002);
		idle();
		`CHK({pin_oe_n_o, pin_out_o & 12'h00C}, 24'hFF3004)
		periph_oe_i <= 12'h010;
		wr(5'h1A, 12'h000);
		wr(5'h12, 12'h001);
		wr(gpio_pkg::ADR_DIR_SET, 12'h400);
		idle();
		`CHK(pin_oe_n_o, 12'hBE7)
		wr(5'h16, 12'h010);
		wr(5'h17, 12'h008);
		wr(5'h18, 12'h018);
		{ext_en, ext_val} <= {12'h300, 12'h100};
		idle();
		ext_en <= 12'h200;
		idle();
		`CHK({pull_up_o, pull_dn_o}, 24'h140080)
		rd(gpio_pkg::ADR_DATA, 12'h100, 12'h100);
		{ext_en, ext_val} <= {12'h300, 12'h000};
		idle();
		ext_en <= 12'h200;
		idle();
		`CHK({pull_up_o, pull_dn_o}, 24'h040180)
		deep_pd_i <= 1'b1;
		idle();
		`CHK({pull_up_o, pull_dn_o}, 24'h040080)
		deep_pd_i <= 1'b0;
		wr(5'h19, 12'h0E0);
		wr(5'h14, 12'h101);
		wr(5'h13, 12'h600);
		wr(5'h11, 12'h200);
		idle();
		`CHK({hyst_o, inmode_o, filt_o}, {3{12'h200}})
		`CHK(bus_glitch_o, 12'h020)
		`CHK({sink_en_o, sink_sel_o}, 24'h008008)
		wr(gpio_pkg::ADR_SET, 12'h008);
		wr(gpio_pkg::ADR_IRQ_EN, 12'h200);
		wr(gpio_pkg::ADR_IRQ_STAT, 12'hFFF);
		idle();
		`CHK({sink_sel_o, port_irq_o}, 13'h0000)
		ext_val <= 12'h200;
		idle();
		`CHK({wake_o[9], port_irq_o}, 2'b11)
		rd(gpio_pkg::ADR_IRQ_STAT, 12'h200, 12'h200);
		wr(gpio_pkg::ADR_IRQ_EN, 12'h000);
		idle();
		`CHK(port_irq_o, 1'b0)
		test_done();
	end
endmodule // gpio_port_with_pad_config_tb
`default_nettype wire
